// [tcr_pkg.sv]
`default_nettype none
package tcr_pkg;
    // Byte offsets on the APB bus
    localparam logic [7:0] OFS_COUNT_HI = 8'h00;
    localparam logic [7:0] OFS_COUNT_LO = 8'h04;
    localparam logic [7:0] OFS_PIN_ACTION = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN1 = 8'h0C;
    localparam logic [7:0] OFS_FLAGS1 = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN2 = 8'h14;
    localparam logic [7:0] OFS_FLAGS2 = 8'h18;
    localparam logic [7:0] OFS_ACC_RATE = 8'h1C;

    // Flag-register-1 positions
    localparam int FLG1_CMP1 = 7;
    localparam int FLG1_CMP4 = 4;
    localparam int FLG1_CH45 = 3;
    localparam int FLG1_CAP1 = 2;
    // Flag-register-2 positions; bits 3..0 do not exist
    localparam int FLG2_OVF = 7;
    localparam int FLG2_PERIODIC = 6;
    localparam int FLG2_ACC_OVF = 5;
    localparam int FLG2_ACC_EDGE = 4;
    localparam logic [7:0] EN2_IMPL_MASK = 8'hF3;
    localparam logic [7:0] FLG2_IMPL_MASK = 8'hF0;
    // Accumulator-and-rate control positions
    localparam int ACC_CH45_SEL = 2;
    localparam int ACC_RATE_LSB = 0;

    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

    // Prescaler select write window after reset
    localparam int PRESCALE_WINDOW_CYCLES = 64;
    // Periodic base divider exponent
    localparam int PERIODIC_BASE_LOG2 = 13;
    localparam int PERIODIC_BASE_CYCLES = 8192;

    typedef struct packed {
        logic [4:0][15:0] value; // Index 0 is channel one
    } tcr_cmp_type;

    typedef struct packed {
        logic cap1;
        logic cap2;
        logic cap3;
        logic cap4;
        logic accum_ovf;
        logic accum_edge;
    } tcr_evt_type;
endpackage
`default_nettype wire

// [tcr_timer_core.sv]
// Our own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module tcr_timer_core
(
    input wire logic pclk, // 100 MHz bus and timer clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic mode_normal, // High in normal operating modes
    input wire tcr_pkg::tcr_cmp_type cmp_vals, // Compare values, channels 1..5
    input wire tcr_pkg::tcr_evt_type evt_in, // One-cycle event pulses
    output logic [3:0] oc_pin, // Compare pin levels, channels 2..5
    output logic [3:0] oc_pin_oe_n, // Low while timer drives the pin
    output logic irq_cmp_cap, // Request from first flag register
    output logic irq_ovf_periodic // Request from second flag register
);
    import tcr_pkg::*;

    logic [15:0] count_reg;
    logic [3:0] pre_cnt_reg;
    logic [15:0] rti_div_reg;
    logic [7:0] pin_action_reg;
    logic [7:0] irq_en1_reg;
    logic [7:0] flags1_reg;
    logic [7:0] irq_en2_reg;
    logic [7:0] flags2_reg;
    logic [7:0] acc_rate_reg;
    logic [7:0] lo_latch_reg;
    logic lo_armed_reg;
    logic [6:0] age_reg;
    logic pr_written_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [3:0] oc_pin_reg;
    logic [3:0] oc_oe_n_reg;
    logic irq1_reg;
    logic irq2_reg;

    logic [15:0] count_next;
    logic count_tick;
    logic rti_timeout;
    logic [3:0] pre_mask;
    logic [15:0] rti_mask;
    logic [4:0] match;
    logic sel_cap4;
    logic wr_done;
    logic rd_done;
    logic [7:0] wbyte;
    logic pr_open;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] clr1;
    logic [7:0] clr2;
    logic [31:0] rd_mux;
    logic addr_ok;

    assign sel_cap4 = acc_rate_reg[ACC_CH45_SEL];
    assign wr_done = psel && penable && pready_reg && pwrite;
    assign rd_done = psel && penable && pready_reg && !pwrite;
    assign wbyte = pwdata[7:0];

    // Prescaler: divide by 1, 4, 8 or 16
    always_comb
    begin
        case (irq_en2_reg[1:0])
            2'b00: pre_mask = 4'h0;
            2'b01: pre_mask = 4'h3;
            2'b10: pre_mask = 4'h7;
            default: pre_mask = 4'hF;
        endcase
    end
    assign count_tick = ((pre_cnt_reg & pre_mask) == pre_mask);
    assign count_next = count_reg + 16'h0001;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_cnt_reg <= 4'h0;
        else
            pre_cnt_reg <= pre_cnt_reg + 4'h1;
    end

    // Only increments; the bus has no write path into the count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_reg <= COUNT_RESET;
        else if (count_tick)
            count_reg <= count_next;
    end

    // Periodic divider never stops, so timeouts are spaced by whole periods
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rti_div_reg <= 16'h0000;
        else
            rti_div_reg <= rti_div_reg + 16'h0001;
    end
    always_comb
    begin
        case (acc_rate_reg[ACC_RATE_LSB +: 2])
            2'b00: rti_mask = 16'h1FFF;
            2'b01: rti_mask = 16'h3FFF;
            2'b10: rti_mask = 16'h7FFF;
            default: rti_mask = 16'hFFFF;
        endcase
    end
    // First timeout lands a full period after reset
    assign rti_timeout = ((rti_div_reg & rti_mask) == rti_mask);

    // Compare matches on the new count value
    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            match[i] = count_tick && (count_next == cmp_vals.value[i]);
        end
        match[4] = match[4] && !sel_cap4;
    end

    // Event sets
    always_comb
    begin
        set1 = 8'h00;
        set1[FLG1_CMP1 -: 4] = {match[0], match[1], match[2], match[3]};
        set1[FLG1_CH45] = sel_cap4 ? evt_in.cap4 : match[4];
        set1[FLG1_CAP1 -: 3] = {evt_in.cap1, evt_in.cap2, evt_in.cap3};
        set2 = 8'h00;
        set2[FLG2_OVF] = count_tick && (count_reg == COUNT_ALL_ONES);
        set2[FLG2_PERIODIC] = rti_timeout;
        set2[FLG2_ACC_OVF] = evt_in.accum_ovf;
        set2[FLG2_ACC_EDGE] = evt_in.accum_edge;
        clr1 = (wr_done && paddr == OFS_FLAGS1) ? wbyte : 8'h00;
        clr2 = (wr_done && paddr == OFS_FLAGS2) ? (wbyte & FLG2_IMPL_MASK) : 8'h00;
    end

    // A set in the same cycle as its clear wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags1_reg <= REG8_RESET;
            flags2_reg <= REG8_RESET;
        end
        else
        begin
            flags1_reg <= (flags1_reg & ~clr1) | set1;
            flags2_reg <= ((flags2_reg & ~clr2) | set2) & FLG2_IMPL_MASK;
        end
    end

    // Prescale select write window
    assign pr_open = !mode_normal || (!pr_written_reg && age_reg < 7'(PRESCALE_WINDOW_CYCLES));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            age_reg <= 7'h00;
        else if (age_reg < 7'(PRESCALE_WINDOW_CYCLES))
            age_reg <= age_reg + 7'h01;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pr_written_reg <= 1'b0;
        else if (wr_done && paddr == OFS_IRQ_EN2 && mode_normal)
            pr_written_reg <= 1'b1;
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_action_reg <= REG8_RESET;
            irq_en1_reg <= REG8_RESET;
            irq_en2_reg <= REG8_RESET;
            acc_rate_reg <= REG8_RESET;
        end
        else if (wr_done)
        begin
            case (paddr)
                OFS_PIN_ACTION: pin_action_reg <= wbyte;
                OFS_IRQ_EN1: irq_en1_reg <= wbyte;
                OFS_IRQ_EN2:
                begin
                    irq_en2_reg[7:4] <= wbyte[7:4];
                    if (pr_open)
                        irq_en2_reg[1:0] <= wbyte[1:0];
                end
                OFS_ACC_RATE: acc_rate_reg <= wbyte;
                default: ;
            endcase
        end
    end

    // Read mux
    always_comb
    begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFS_COUNT_HI: rd_mux[7:0] = count_reg[15:8];
            OFS_COUNT_LO: rd_mux[7:0] = lo_armed_reg ? lo_latch_reg : count_reg[7:0];
            OFS_PIN_ACTION: rd_mux[7:0] = pin_action_reg;
            OFS_IRQ_EN1: rd_mux[7:0] = irq_en1_reg;
            OFS_FLAGS1: rd_mux[7:0] = flags1_reg;
            OFS_IRQ_EN2: rd_mux[7:0] = irq_en2_reg & EN2_IMPL_MASK;
            OFS_FLAGS2: rd_mux[7:0] = flags2_reg & FLG2_IMPL_MASK;
            OFS_ACC_RATE: rd_mux[7:0] = acc_rate_reg;
            default: addr_ok = 1'b0;
        endcase
    end

    // One wait state keeps every bus output on a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else if (psel && penable && !pready_reg)
        begin
            pready_reg <= 1'b1;
            pslverr_reg <= !addr_ok;
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
        end
        else
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
    end

    // Low byte frozen at the high-byte read, held for the very next access only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lo_latch_reg <= 8'h00;
        else if (psel && penable && !pready_reg && !pwrite && paddr == OFS_COUNT_HI)
            lo_latch_reg <= count_reg[7:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lo_armed_reg <= 1'b0;
        else if (rd_done || wr_done)
            lo_armed_reg <= rd_done && paddr == OFS_COUNT_HI;
    end

    // Pin actions on every match of channels 2..5, flags ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oc_pin_reg <= 4'h0;
            oc_oe_n_reg <= 4'hF;
        end
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                oc_oe_n_reg[k] <= (pin_action_reg[7 - 2 * k -: 2] == 2'b00)
                    || (k == 3 && sel_cap4);
                if (match[k + 1])
                begin
                    case (pin_action_reg[7 - 2 * k -: 2])
                        2'b01: oc_pin_reg[k] <= !oc_pin_reg[k];
                        2'b10: oc_pin_reg[k] <= 1'b0;
                        2'b11: oc_pin_reg[k] <= 1'b1;
                        default: ;
                    endcase
                end
            end
        end
    end

    // Interrupt requests
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq1_reg <= 1'b0;
            irq2_reg <= 1'b0;
        end
        else
        begin
            irq1_reg <= |(flags1_reg & irq_en1_reg);
            irq2_reg <= |(flags2_reg & irq_en2_reg & FLG2_IMPL_MASK);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign oc_pin = oc_pin_reg;
    assign oc_pin_oe_n = oc_oe_n_reg;
    assign irq_cmp_cap = irq1_reg;
    assign irq_ovf_periodic = irq2_reg;

    // Helper: cycles since reset, saturating
    logic [16:0] since_rst;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_rst <= 17'h0_0000;
        else if (!since_rst[16])
            since_rst <= since_rst + 17'h0_0001;
    end

    a_count_ro: assert property (@(posedge pclk) disable iff (!presetn)
        (count_reg != $past(count_reg)) |-> (count_reg == $past(count_reg) + 16'h0001))
        else $error("count changed other than by one");

    a_hi_latch: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == OFS_COUNT_LO && lo_armed_reg) |-> prdata[7:0] == lo_latch_reg)
        else $error("low byte not taken from latch");

    a_pin_set: assert property (@(posedge pclk) disable iff (!presetn)
        (match[1] && pin_action_reg[7:6] == 2'b11) |=> oc_pin[0] && !oc_pin_oe_n[0])
        else $error("drive-high action missed");

    a_oc5_gated: assert property (@(posedge pclk) disable iff (!presetn)
        sel_cap4 ##1 sel_cap4 |-> oc_pin_oe_n[3] && $stable(oc_pin[3]))
        else $error("channel five pin active while capture selected");

    a_irq1_gate: assert property (@(posedge pclk) disable iff (!presetn)
        ((flags1_reg & irq_en1_reg) != 8'h00) |=> irq_cmp_cap)
        else $error("enabled flag gave no request");

    a_chan45_src: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_cap4 && evt_in.cap4) |=> flags1_reg[FLG1_CH45])
        else $error("capture four did not set shared flag");

    a_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (count_tick && count_reg == COUNT_ALL_ONES) |=> flags2_reg[FLG2_OVF] && count_reg == 16'h0000)
        else $error("rollover did not set overflow flag");

    a_ovf_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (flags2_reg[FLG2_OVF] && !irq_en2_reg[FLG2_OVF]
        && (flags2_reg[6:4] & irq_en2_reg[6:4]) == 3'b000) |=> !irq_ovf_periodic)
        else $error("overflow request while disabled");

    a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && paddr == OFS_FLAGS2 && !pwrite) |-> prdata[3:0] == 4'h0)
        else $error("unimplemented flag bits not zero");

    a_pr_locked: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_normal && since_rst > 17'd80) |=> $stable(irq_en2_reg[1:0]))
        else $error("prescale select changed after window");

    a_rti_first: assert property (@(posedge pclk) disable iff (!presetn)
        (since_rst < 17'(PERIODIC_BASE_CYCLES)) |-> !flags2_reg[FLG2_PERIODIC])
        else $error("periodic flag before first full period");

    a_rti_source: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flags2_reg[FLG2_PERIODIC]) |-> $past(rti_timeout))
        else $error("periodic flag set without a timeout");
endmodule // tcr_timer_core
`default_nettype wire

// [tcr_pin_partner.sv]
`default_nettype none
module tcr_pin_partner
(
    input wire logic pclk, // Timer clock
    input wire logic [3:0] oc_pin, // Timer pin levels
    input wire logic [3:0] oc_pin_oe_n, // Low while timer drives
    output var tcr_pkg::tcr_cmp_type cmp_vals, // Compare values
    output var tcr_pkg::tcr_evt_type evt_in, // Event pulses
    output logic [3:0] pin_lvl // Resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcr_pkg::*;

    // Board pull-up wins on a released pin
    assign pin_lvl = (oc_pin & ~oc_pin_oe_n) | oc_pin_oe_n;

    initial
    begin
        cmp_vals = {5{16'hFFFF}};
        evt_in = '0;
    end

    task automatic set_cmp(input logic [15:0] m);
        @(posedge pclk);
        cmp_vals <= {5{m}};
    endtask

    // One-cycle pulse, as the upstream edge detector gives
    task automatic pulse(input logic [5:0] e);
        @(posedge pclk);
        evt_in <= tcr_evt_type'(e);
        @(posedge pclk);
        evt_in <= '0;
    endtask
endmodule // tcr_pin_partner
`default_nettype wire

// [timer_compare_rti_core_test.sv]
`default_nettype none
module timer_compare_rti_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tcr_pkg::*;

    localparam int LIMIT = 90000;
    localparam int SPAN = 320;
    logic pclk, presetn, psel, penable, pwrite, mode_normal, pready, pslverr, ev;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0] oc_pin, oc_pin_oe_n, pin_lvl;
    logic irq_cmp_cap, irq_ovf_periodic;
    wire tcr_cmp_type cmp_vals;
    wire tcr_evt_type evt_in;
    int cyc = 0;
    int rel, rd_cyc, bad_count, total_checks;
    int shf [4] = '{0, 2, 3, 4};
    logic [7:0] act [2] = '{8'h1B, 8'hE4};
    logic [3:0] pexp [2] = '{4'hB, 4'hD};

    tcr_timer_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_normal(mode_normal), .cmp_vals(cmp_vals), .evt_in(evt_in),
        .oc_pin(oc_pin), .oc_pin_oe_n(oc_pin_oe_n), .irq_cmp_cap(irq_cmp_cap),
        .irq_ovf_periodic(irq_ovf_periodic));
    tcr_pin_partner far (.pclk(pclk), .oc_pin(oc_pin), .oc_pin_oe_n(oc_pin_oe_n),
        .cmp_vals(cmp_vals), .evt_in(evt_in), .pin_lvl(pin_lvl));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Bus hang is cut short here as well
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        rd_cyc = cyc;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rv, exp);
        chk(32'(ev), 32'h0000_0000);
    endtask

    // High byte first so the low byte comes from the latch
    task automatic cnt(output logic [15:0] v);
        apb(1'b0, OFS_COUNT_HI, 8'h00);
        v[15:8] = rv[7:0];
        apb(1'b0, OFS_COUNT_LO, 8'h00);
        v[7:0] = rv[7:0];
    endtask

    task automatic do_reset;
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rel = cyc;
    endtask

    task automatic wait_until(input int t);
        while (cyc - rel < t) @(posedge pclk);
    endtask

    task automatic irq_is(input logic irq_sel, input logic exp);
        repeat (3) @(posedge pclk);
        chk(32'(irq_sel ? irq_ovf_periodic : irq_cmp_cap), 32'(exp));
    endtask

    initial
    begin
        logic [15:0] v0, v1;
        logic [31:0] lo1;
        int s0, c1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        mode_normal = 1'b1;
        do_reset();
        for (int a = 8; a < 32; a += 4)
            rd(8'(a), 32'h0000_0000);
        apb(1'b0, 8'h20, 8'h00);
        chk(32'(ev), 32'h0000_0001);
        wr(OFS_IRQ_EN2, 8'h01);
        rd(OFS_IRQ_EN2, 32'h0000_0001);
        wr(OFS_IRQ_EN2, 8'h02);
        rd(OFS_IRQ_EN2, 32'h0000_0001);
        mode_normal <= 1'b0;
        for (int k = 3; k >= 0; k--)
        begin
            wr(OFS_IRQ_EN2, 8'(k));
            s0 = cyc;
            cnt(v0);
            wr(OFS_COUNT_HI, 8'hFF);
            while (cyc < s0 + SPAN) @(posedge pclk);
            cnt(v1);
            chk(32'(16'(v1 - v0)), 32'(SPAN >> shf[k]));
        end
        apb(1'b0, OFS_COUNT_HI, 8'h00);
        c1 = rd_cyc;
        apb(1'b0, OFS_COUNT_LO, 8'h00);
        lo1 = rv;
        apb(1'b0, OFS_PIN_ACTION, 8'h00);
        apb(1'b0, OFS_COUNT_LO, 8'h00);
        chk(32'(8'(rv[7:0] - lo1[7:0])), 32'(8'(rd_cyc - c1)));
        // Second round keeps the flags set on purpose
        for (int k = 0; k < 2; k++)
        begin
            wr(OFS_PIN_ACTION, act[k]);
            cnt(v0);
            far.set_cmp(v0 + 16'h00C8);
            repeat (300) @(posedge pclk);
            chk(32'(pin_lvl), 32'(pexp[k]));
            rd(OFS_FLAGS1, 32'h0000_00F8);
        end
        wr(OFS_FLAGS1, 8'h00);
        rd(OFS_FLAGS1, 32'h0000_00F8);
        wr(OFS_FLAGS1, 8'h08);
        rd(OFS_FLAGS1, 32'h0000_00F0);
        wr(OFS_FLAGS1, 8'hFF);
        far.pulse(6'h04);
        rd(OFS_FLAGS1, 32'h0000_0000);
        wr(OFS_ACC_RATE, 8'h04);
        wr(OFS_PIN_ACTION, 8'h03);
        cnt(v0);
        far.set_cmp(v0 + 16'h00C8);
        repeat (300) @(posedge pclk);
        chk(32'(oc_pin_oe_n[3]), 32'h0000_0001);
        rd(OFS_FLAGS1, 32'h0000_00F0);
        wr(OFS_IRQ_EN1, 8'h08);
        irq_is(1'b0, 1'b0);
        far.pulse(6'h04);
        irq_is(1'b0, 1'b1);
        far.pulse(6'h38);
        rd(OFS_FLAGS1, 32'h0000_00FF);
        wr(OFS_FLAGS1, 8'hFF);
        irq_is(1'b0, 1'b0);
        far.pulse(6'h03);
        rd(OFS_FLAGS2, 32'h0000_0030);
        wr(OFS_IRQ_EN2, 8'h20);
        irq_is(1'b1, 1'b1);
        wr(OFS_FLAGS2, 8'h1F);
        rd(OFS_FLAGS2, 32'h0000_0020);
        wr(OFS_FLAGS2, 8'h20);
        irq_is(1'b1, 1'b0);
        wr(OFS_IRQ_EN2, 8'hFC);
        rd(OFS_IRQ_EN2, 32'h0000_00F0);
        mode_normal <= 1'b1;
        do_reset();
        wait_until(70);
        wr(OFS_IRQ_EN2, 8'h03);
        rd(OFS_IRQ_EN2, 32'h0000_0000);
        wait_until(8180);
        rd(OFS_FLAGS2, 32'h0000_0000);
        wait_until(8200);
        rd(OFS_FLAGS2, 32'h0000_0040);
        irq_is(1'b1, 1'b0);
        wr(OFS_IRQ_EN2, 8'h40);
        irq_is(1'b1, 1'b1);
        wr(OFS_FLAGS2, 8'h40);
        rd(OFS_FLAGS2, 32'h0000_0000);
        wait_until(16380);
        rd(OFS_FLAGS2, 32'h0000_0000);
        wait_until(16400);
        rd(OFS_FLAGS2, 32'h0000_0040);
        wr(OFS_ACC_RATE, 8'h01);
        wr(OFS_FLAGS2, 8'h40);
        wait_until(24600);
        rd(OFS_FLAGS2, 32'h0000_0000);
        wait_until(32780);
        rd(OFS_FLAGS2, 32'h0000_0040);
        wr(OFS_ACC_RATE, 8'h03);
        wr(OFS_FLAGS2, 8'h40);
        wr(OFS_IRQ_EN2, 8'h00);
        wait_until(49160);
        rd(OFS_FLAGS2, 32'h0000_0000);
        wait_until(65550);
        rd(OFS_FLAGS2, 32'h0000_00C0);
        irq_is(1'b1, 1'b0);
        wr(OFS_IRQ_EN2, 8'h80);
        irq_is(1'b1, 1'b1);
        wr(OFS_FLAGS2, 8'h80);
        rd(OFS_FLAGS2, 32'h0000_0040);
        irq_is(1'b1, 1'b0);
        finish_test();
    end
endmodule // timer_compare_rti_core_test
`default_nettype wire
